// >>> cms_regs.svh
// Register select codes, field positions and reset values of the sequencer
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH

`define CMS_SEL_CACHE_CONFIGURATION_REGISTER 5'h00
`define CMS_SEL_GWB 5'h01
`define CMS_SEL_GWBINV 5'h02
`define CMS_SEL_BLK_BIT 4
`define CMS_SEL_CNT_BIT 0
`define CMS_SEL_KIND_HI 3
`define CMS_SEL_KIND_LO 1
`define CMS_CACHE_CONFIGURATION_REGISTER_ID_BIT 8
`define CMS_CACHE_CONFIGURATION_REGISTER_IP_BIT 9
`define CMS_CMD_C_BIT 0
`define CMS_WC_HI 15
`define CMS_BAR_RESET 32'h0000_0000
`define CMS_WC_RESET 16'h0000
`define CMS_CBIT_RESET 1'h0
`define CMS_WORD_PAD 2'h0
`define CMS_WC_UPPER 16'h0000
`define CMS_ONE_LINE 32'h0000_0001

`endif

// >>> cms_pkg.sv
// Types shared by the cache maintenance sequencer and its helpers
package cms_pkg;

  typedef enum logic [1:0] {
    ACT_NONE  = 2'b00,
    ACT_INV   = 2'b01,
    ACT_WB    = 2'b10,
    ACT_WBINV = 2'b11
  } cms_act_t;

  typedef enum logic [2:0] {
    BK_L2_WB    = 3'b000,
    BK_L2_WBINV = 3'b001,
    BK_L2_INV   = 3'b010,
    BK_L1P_INV  = 3'b011,
    BK_L1D_WBI  = 3'b100,
    BK_L1D_INV  = 3'b101
  } cms_blk_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10
  } cms_state_t;

  typedef struct packed {
    logic write;
    logic [4:0] sel;
    logic [31:0] wdata;
  } cms_req_t;

  typedef struct packed {
    cms_act_t act;
    logic glob;
    logic held_only;
    logic [31:0] addr;
  } cms_cmd_t;

  typedef struct packed {
    cms_act_t l1p;
    cms_act_t l1d;
    cms_act_t l2;
    logic held_only;
  } cms_plan_t;

endpackage

// >>> cms_cmd_port.sv
// One cache command port: holds a command until the cache acknowledges it
`timescale 1ns/1ps
module cms_cmd_port
  import cms_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // From the sequencer
  input wire logic load,
  input cms_cmd_t cmd_in,
  // Toward the cache
  output logic valid,
  output cms_cmd_t cmd,
  input wire logic ack
);

  logic valid_q;
  cms_cmd_t cmd_q;
  logic take;

  assign take = load && (cmd_in.act != ACT_NONE);
  assign valid = valid_q;
  assign cmd = cmd_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      valid_q <= 1'b0;
    end else if (take) begin
      valid_q <= 1'b1;
    end else if (ack) begin
      valid_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= '0;
    end else if (take) begin
      cmd_q <= cmd_in;
    end
  end

  a_no_overlap: // [R1]
  assert property (@(posedge clock) disable iff (!nrst) take |-> !valid_q)
    else $error("command loaded over a pending one");

  a_cmd_hold: // [R1]
  assert property (@(posedge clock) disable iff (!nrst)
    valid_q && !ack |=> valid_q && $stable(cmd_q))
    else $error("pending command dropped or changed");

endmodule

// >>> cms_line_walk.sv
// Walks the cache lines covered by a block command, one line per step
`timescale 1ns/1ps
`include "cms_regs.svh"
module cms_line_walk #(
  parameter int LINE_SHIFT = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic [31:0] base,
  input wire logic [15:0] words,
  input wire logic step,
  // Current line
  output logic [31:0] line_addr,
  output logic last
);

  logic [31:0] cur_q;
  logic [31:0] end_q;
  logic [31:0] end_byte;

  // Whole lines are always covered, even for partial first or last lines
  assign end_byte = base + {14'h0000, words, `CMS_WORD_PAD} - `CMS_ONE_LINE;
  assign line_addr = cur_q << LINE_SHIFT;
  assign last = (cur_q == end_q);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur_q <= `CMS_BAR_RESET;
    end else if (start) begin
      cur_q <= base >> LINE_SHIFT;
    end else if (step) begin
      cur_q <= cur_q + `CMS_ONE_LINE;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      end_q <= `CMS_BAR_RESET;
    end else if (start) begin
      end_q <= end_byte >> LINE_SHIFT;
    end
  end

  a_walk_start: // [R18]
  assert property (@(posedge clock) disable iff (!nrst)
    start |=> cur_q == ($past(base) >> LINE_SHIFT))
    else $error("walk did not begin at the base line");

  a_walk_step: // [R12]
  assert property (@(posedge clock) disable iff (!nrst)
    step && !start |=> cur_q == $past(cur_q) + `CMS_ONE_LINE)
    else $error("walk skipped or repeated a line");

endmodule

// >>> cms_sequencer.sv
// Program-initiated cache maintenance sequencer for a two-level memory
//
// Summary of operation
// R1 - Only one cache operation runs at once
// R2 - Control register accesses may stall while busy
// R3 - Global operation stalls core accesses to its cache
// R4 - Invalidate bit discards first-level cache, no writeback
// R5 - Configuration read after invalidate waits for completion
// R6 - Command bit write starts global writeback or flush
// R7 - Command bit reads one until operation completes
// R8 - Software polls command bit until zero
// R9 - Global writeback keeps lines, flushes held data lines
// R10 - Global flush invalidates all, discards program cache
// R11 - First-level side effects only with second level enabled
// R12 - Block writeback keeps lines, flushes data cache lines
// R13 - Block flush invalidates second level and both caches
// R14 - Block invalidate discards block in all caches
// R15 - Data block invalidate touches only data cache
// R16 - Data block flush leaves program cache alone
// R17 - Software prefers flush over data global invalidate
// R18 - Block starts on non-zero count after base write
// R19 - Count is low 16 bits, upper read zero
// R20 - Count reads non-zero while busy, zero after
// R21 - Base write during operation stalls until done
// R22 - Stalled writes are held and applied later
`timescale 1ns/1ps
`include "cms_regs.svh"
module cms_sequencer
  import cms_pkg::*;
#(
  parameter int LINE_SHIFT = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Core register port
  input wire logic req_valid,
  input cms_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  // System status
  input wire logic l2_cache_en,
  input wire logic mode_busy,
  // Program cache commands
  output logic l1p_cmd_valid,
  output cms_cmd_t l1p_cmd,
  input wire logic l1p_cmd_ack,
  // Data cache commands
  output logic l1d_cmd_valid,
  output cms_cmd_t l1d_cmd,
  input wire logic l1d_cmd_ack,
  // Second-level commands
  output logic l2_cmd_valid,
  output cms_cmd_t l2_cmd,
  input wire logic l2_cmd_ack,
  // Core access stalls and status
  output logic l1p_stall,
  output logic l1d_stall,
  output logic l2_stall,
  output logic op_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Operation plans

  function automatic cms_plan_t plan_global(input logic gwb, input logic gwbinv,
                                            input logic id, input logic ip,
                                            input logic l2en);
    cms_plan_t p;
    p = '{l1p: ACT_NONE, l1d: ACT_NONE, l2: ACT_NONE, held_only: 1'b0};
    if (gwb && l2en) begin
      p = '{l1p: ACT_NONE, l1d: ACT_WBINV, l2: ACT_WB, held_only: 1'b1}; // [R9] [R11]
    end else if (gwbinv && l2en) begin
      p = '{l1p: ACT_INV, l1d: ACT_WBINV, l2: ACT_WBINV, held_only: 1'b1}; // [R10] [R11]
    end else if (!gwb && !gwbinv) begin
      p.l1d = id ? ACT_INV : ACT_NONE; // [R4]
      p.l1p = ip ? ACT_INV : ACT_NONE; // [R4]
    end
    return p;
  endfunction

  function automatic cms_plan_t plan_block(input cms_blk_t kind, input logic l2en);
    cms_plan_t p;
    p = '{l1p: ACT_NONE, l1d: ACT_NONE, l2: ACT_NONE, held_only: 1'b0};
    case (kind)
      BK_L2_WB: begin
        if (l2en) begin
          p = '{l1p: ACT_NONE, l1d: ACT_WBINV, l2: ACT_WB, held_only: 1'b1}; // [R12] [R11]
        end
      end
      BK_L2_WBINV: begin
        if (l2en) begin
          p = '{l1p: ACT_INV, l1d: ACT_WBINV, l2: ACT_WBINV, held_only: 1'b1}; // [R13]
        end
      end
      BK_L2_INV: begin
        if (l2en) begin
          p = '{l1p: ACT_INV, l1d: ACT_INV, l2: ACT_INV, held_only: 1'b1}; // [R14]
        end
      end
      BK_L1P_INV: p.l1p = ACT_INV;
      BK_L1D_WBI: p.l1d = ACT_WBINV; // [R16]
      BK_L1D_INV: p.l1d = ACT_INV; // [R15]
      default: p.l1p = ACT_NONE;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  cms_state_t state_q;
  cms_plan_t plan_q;
  cms_blk_t kind_q;
  logic glob_q;
  logic gwb_q;
  logic gwbinv_q;
  logic [31:0] base_q;
  logic [15:0] count_q;
  logic rsp_valid_q;
  logic [31:0] rsp_data_q;
  logic busy;
  logic stall_req;
  logic accept;
  logic wr;
  logic is_blk;
  logic is_cnt;
  cms_blk_t sel_kind;
  logic start_gwb;
  logic start_gwbinv;
  logic start_l1;
  logic start_blk;
  logic start_any;
  logic ports_idle;
  logic walk_last;
  logic [31:0] walk_addr;
  logic step;
  logic done;
  logic load;
  cms_cmd_t cmd_l1p;
  cms_cmd_t cmd_l1d;
  cms_cmd_t cmd_l2;

  assign busy = (state_q != ST_IDLE);
  assign is_blk = req.sel[`CMS_SEL_BLK_BIT];
  assign is_cnt = req.sel[`CMS_SEL_CNT_BIT];
  assign sel_kind = cms_blk_t'(req.sel[`CMS_SEL_KIND_HI:`CMS_SEL_KIND_LO]);

  // Writes wait for idle so none is lost; polling reads of C and count pass
  always_comb begin
    stall_req = 1'b0;
    if (req.write) begin
      stall_req = busy || mode_busy; // [R2] [R21] [R22] [R1]
    end else if (req.sel == `CMS_SEL_CACHE_CONFIGURATION_REGISTER) begin
      stall_req = busy; // [R5]
    end
  end

  assign req_ready = !stall_req;
  assign accept = req_valid && req_ready;
  assign wr = accept && req.write;

  assign start_gwb = wr && (req.sel == `CMS_SEL_GWB) && req.wdata[`CMS_CMD_C_BIT]; // [R6]
  assign start_gwbinv = wr && (req.sel == `CMS_SEL_GWBINV) && req.wdata[`CMS_CMD_C_BIT]; // [R6]
  assign start_l1 = wr && (req.sel == `CMS_SEL_CACHE_CONFIGURATION_REGISTER) &&
                    (req.wdata[`CMS_CACHE_CONFIGURATION_REGISTER_ID_BIT] || req.wdata[`CMS_CACHE_CONFIGURATION_REGISTER_IP_BIT]); // [R4]
  assign start_blk = wr && is_blk && is_cnt &&
                     (req.wdata[`CMS_WC_HI:0] != `CMS_WC_RESET); // [R18]
  assign start_any = start_gwb || start_gwbinv || start_l1 || start_blk;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  assign ports_idle = !l1p_cmd_valid && !l1d_cmd_valid && !l2_cmd_valid;
  assign load = (state_q == ST_ISSUE);
  assign step = (state_q == ST_WAIT) && ports_idle && !glob_q && !walk_last;
  assign done = (state_q == ST_WAIT) && ports_idle && (glob_q || walk_last);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_any) begin
            state_q <= ST_ISSUE; // [R1]
          end
        end
        ST_ISSUE: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (done) begin
            state_q <= ST_IDLE;
          end else if (step) begin
            state_q <= ST_ISSUE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      plan_q <= '0;
      glob_q <= 1'b0;
      kind_q <= BK_L2_WB;
    end else if (start_blk) begin
      plan_q <= plan_block(sel_kind, l2_cache_en);
      glob_q <= 1'b0;
      kind_q <= sel_kind;
    end else if (start_any) begin
      plan_q <= plan_global(start_gwb, start_gwbinv, req.wdata[`CMS_CACHE_CONFIGURATION_REGISTER_ID_BIT],
                            req.wdata[`CMS_CACHE_CONFIGURATION_REGISTER_IP_BIT], l2_cache_en);
      glob_q <= 1'b1;
    end
  end

  cms_line_walk #(
    .LINE_SHIFT(LINE_SHIFT)
  ) u_walk (
    .clock(clock),
    .nrst(nrst),
    .start(start_blk),
    .base(base_q),
    .words(req.wdata[`CMS_WC_HI:0]),
    .step(step),
    .line_addr(walk_addr),
    .last(walk_last)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cache command ports

  always_comb begin
    cmd_l1p = '{act: plan_q.l1p, glob: glob_q, held_only: plan_q.held_only, addr: walk_addr};
    cmd_l1d = '{act: plan_q.l1d, glob: glob_q, held_only: plan_q.held_only, addr: walk_addr};
    cmd_l2 = '{act: plan_q.l2, glob: glob_q, held_only: 1'b0, addr: walk_addr};
  end

  cms_cmd_port u_l1p (
    .clock(clock),
    .nrst(nrst),
    .load(load),
    .cmd_in(cmd_l1p),
    .valid(l1p_cmd_valid),
    .cmd(l1p_cmd),
    .ack(l1p_cmd_ack)
  );

  cms_cmd_port u_l1d (
    .clock(clock),
    .nrst(nrst),
    .load(load),
    .cmd_in(cmd_l1d),
    .valid(l1d_cmd_valid),
    .cmd(l1d_cmd),
    .ack(l1d_cmd_ack)
  );

  cms_cmd_port u_l2 (
    .clock(clock),
    .nrst(nrst),
    .load(load),
    .cmd_in(cmd_l2),
    .valid(l2_cmd_valid),
    .cmd(l2_cmd),
    .ack(l2_cmd_ack)
  );

  // Global work owns the whole cache, so core traffic to it waits
  assign l1p_stall = busy && glob_q && (plan_q.l1p != ACT_NONE); // [R3]
  assign l1d_stall = busy && glob_q && (plan_q.l1d != ACT_NONE); // [R3]
  assign l2_stall = busy && glob_q && (plan_q.l2 != ACT_NONE); // [R3]
  assign op_busy = busy;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gwb_q <= `CMS_CBIT_RESET;
      gwbinv_q <= `CMS_CBIT_RESET;
    end else begin
      gwb_q <= start_gwb || (gwb_q && !done); // [R7]
      gwbinv_q <= start_gwbinv || (gwbinv_q && !done); // [R7]
    end
  end

  // One physical base/count pair serves every block register alias
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      base_q <= `CMS_BAR_RESET;
    end else if (wr && is_blk && !is_cnt) begin
      base_q <= req.wdata; // [R21]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_q <= `CMS_WC_RESET;
    end else if (start_blk) begin
      count_q <= req.wdata[`CMS_WC_HI:0]; // [R19]
    end else if (done) begin
      count_q <= `CMS_WC_RESET; // [R20]
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= accept && !req.write;
      if (accept && !req.write) begin
        if (is_blk) begin
          rsp_data_q <= is_cnt ? {`CMS_WC_UPPER, count_q} : base_q; // [R19] [R20]
        end else if (req.sel == `CMS_SEL_GWB) begin
          rsp_data_q <= {31'h0000_0000, gwb_q}; // [R7]
        end else if (req.sel == `CMS_SEL_GWBINV) begin
          rsp_data_q <= {31'h0000_0000, gwbinv_q}; // [R7]
        end else begin
          rsp_data_q <= '0;
        end
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_one_op: // [R1]
  assert property (@(posedge clock) disable iff (!nrst) busy |-> !start_any)
    else $error("second operation started while busy");

  a_ctl_write_stall: // [R2]
  assert property (@(posedge clock) disable iff (!nrst)
    busy && req_valid && req.write |-> !req_ready)
    else $error("control write taken during an operation");

  a_global_stall: // [R3]
  assert property (@(posedge clock) disable iff (!nrst)
    l1d_cmd_valid && l1d_cmd.glob |-> l1d_stall)
    else $error("data cache not stalled during global work");

  a_id_inv_only: // [R4]
  assert property (@(posedge clock) disable iff (!nrst)
    start_l1 && !req.wdata[`CMS_CACHE_CONFIGURATION_REGISTER_IP_BIT] |=> ##1
    l1d_cmd_valid && l1d_cmd.act == ACT_INV && !l2_cmd_valid && !l1p_cmd_valid)
    else $error("data invalidate wrong or touched other caches");

  a_cache_configuration_register_read_wait: // [R5]
  assert property (@(posedge clock) disable iff (!nrst)
    busy && req_valid && !req.write && req.sel == `CMS_SEL_CACHE_CONFIGURATION_REGISTER |-> !req_ready)
    else $error("configuration read passed a running invalidate");

  a_cbit_held: // [R7]
  assert property (@(posedge clock) disable iff (!nrst)
    start_gwb |=> gwb_q && busy ##1 (gwb_q throughout (busy [*2])))
    else $error("command bit dropped before completion");

  a_gwb_keeps_l1p: // [R9]
  assert property (@(posedge clock) disable iff (!nrst)
    gwb_q |-> !l1p_cmd_valid && (!l2_cmd_valid || l2_cmd.act == ACT_WB))
    else $error("global writeback touched program cache");

  a_gwbinv_plan: // [R10]
  assert property (@(posedge clock) disable iff (!nrst)
    start_gwbinv && l2_cache_en |=> ##1
    l1p_cmd_valid && l1p_cmd.act == ACT_INV && l2_cmd.act == ACT_WBINV)
    else $error("global flush plan wrong");

  a_sram_no_effect: // [R11]
  assert property (@(posedge clock) disable iff (!nrst)
    (start_gwb || start_gwbinv) && !l2_cache_en |=> ##1 ports_idle && done)
    else $error("second-level operation acted in all-SRAM mode");

  a_wc_busy: // [R20]
  assert property (@(posedge clock) disable iff (!nrst)
    busy && !glob_q |-> count_q != `CMS_WC_RESET)
    else $error("count read zero during a block operation");

  a_wc_clear: // [R20]
  assert property (@(posedge clock) disable iff (!nrst)
    done |=> count_q == `CMS_WC_RESET && !busy && !gwb_q && !gwbinv_q)
    else $error("status not cleared at completion");

endmodule

// >>> cms_cache_model.sv
// Cache-side model: takes one command and acknowledges it after a set delay
`timescale 1ns/1ps
module cms_cache_model #(
  parameter int LAT = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Command handshake
  input wire logic valid,
  output logic ack
);
  logic [7:0] cnt_q;

  // One pulse per command; the count restarts, so a valid still held is acked again only after another full delay
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      ack <= 1'b0;
    end else if (valid && !ack && cnt_q == LAT[7:0]) begin
      ack <= 1'b1;
      cnt_q <= 8'h00;
    end else begin
      ack <= 1'b0;
      cnt_q <= (valid && !ack) ? cnt_q + 8'h01 : 8'h00;
    end
  end
endmodule

// >>> cms_sequencer_tb.sv
// Self-checking bench for the cache maintenance sequencer
`timescale 1ns/1ps
module cms_sequencer_tb;
  import cms_pkg::*;
  logic clock, nrst, req_valid, req_ready, rsp_valid, l2_cache_en, mode_busy;
  cms_req_t req;
  logic [31:0] rsp_data, q;
  logic l1p_cmd_valid, l1d_cmd_valid, l2_cmd_valid, l1p_cmd_ack, l1d_cmd_ack, l2_cmd_ack;
  cms_cmd_t l1p_cmd, l1d_cmd, l2_cmd;
  logic l1p_stall, l1d_stall, l2_stall, op_busy;
  int n_errors, n_tests, cycles, w;
  int n_seen [3];
  cms_cmd_t seen [3];

  cms_sequencer cms_sequencer_i (.clock(clock), .nrst(nrst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .l2_cache_en(l2_cache_en), .mode_busy(mode_busy), .l1p_cmd_valid(l1p_cmd_valid),
    .l1p_cmd(l1p_cmd), .l1p_cmd_ack(l1p_cmd_ack), .l1d_cmd_valid(l1d_cmd_valid),
    .l1d_cmd(l1d_cmd), .l1d_cmd_ack(l1d_cmd_ack), .l2_cmd_valid(l2_cmd_valid),
    .l2_cmd(l2_cmd), .l2_cmd_ack(l2_cmd_ack), .l1p_stall(l1p_stall),
    .l1d_stall(l1d_stall), .l2_stall(l2_stall), .op_busy(op_busy));
  // Unequal delays so the caches finish in a different order
  cms_cache_model #(.LAT(1)) p_model_i (.clock(clock), .nrst(nrst), .valid(l1p_cmd_valid),
    .ack(l1p_cmd_ack));
  cms_cache_model #(.LAT(3)) d_model_i (.clock(clock), .nrst(nrst), .valid(l1d_cmd_valid),
    .ack(l1d_cmd_ack));
  cms_cache_model #(.LAT(5)) l2_model_i (.clock(clock), .nrst(nrst), .valid(l2_cmd_valid),
    .ack(l2_cmd_ack));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("unexpected at %0t: run too long", $time);
      final_report();
    end
  end

  // Log every accepted command per cache: 0 program, 1 data, 2 second level
  always @(posedge clock) begin
    if (l1p_cmd_valid && l1p_cmd_ack) begin
      n_seen[0]++;
      seen[0] = l1p_cmd;
    end
    if (l1d_cmd_valid && l1d_cmd_ack) begin
      n_seen[1]++;
      seen[1] = l1d_cmd;
    end
    if (l2_cmd_valid && l2_cmd_ack) begin
      n_seen[2]++;
      seen[2] = l2_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic clear();
    n_seen = '{0, 0, 0};
  endtask

  // Request held until ready is seen at a falling edge; waits counts stalled cycles
  task automatic reg_op(input logic wr, input logic [4:0] s, input logic [31:0] d,
                        output logic [31:0] rq, output int waits);
    waits = 0;
    rq = 32'h0000_0000;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{write: wr, sel: s, wdata: d};
    @(negedge clock);
    while (req_ready !== 1'b1 && waits < 3000) begin
      waits++;
      @(negedge clock);
    end
    @(posedge clock);
    req_valid <= 1'b0;
    if (!wr) begin
      @(negedge clock);
      chk(rsp_valid === 1'b1, "no read response");
      rq = rsp_data;
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(negedge clock);
    while (op_busy !== 1'b0 && n < 3000) begin
      n++;
      @(negedge clock);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge clock);
    chk(req_ready === 1'b1 && op_busy === 1'b0 && rsp_valid === 1'b0, "reset state");
    chk({l1p_stall, l1d_stall, l2_stall, l1p_cmd_valid, l1d_cmd_valid} === 5'h00, "reset");
  endtask

  task automatic t_global(input logic [4:0] s, input cms_act_t p, input cms_act_t d,
                          input cms_act_t l);
    int k;
    k = 0;
    clear();
    reg_op(1'b1, s, 32'h0000_0001, q, w);
    @(negedge clock);
    chk(l2_stall === 1'b1 && l1d_stall === 1'b1, "no stall");
    chk(p != ACT_NONE || l1p_stall === 1'b0, "program cache stalled");
    reg_op(1'b0, s, 32'h0000_0000, q, w);
    chk(q[0] === 1'b1, "command bit clear while busy");
    while (q[0] !== 1'b0 && k < 50) begin
      k++;
      reg_op(1'b0, s, 32'h0000_0000, q, w);
    end
    chk(op_busy === 1'b0 && l2_stall === 1'b0 && l1d_stall === 1'b0, "busy at zero");
    chk(n_seen[2] === 1 && seen[2].act === l && seen[2].glob === 1'b1, "l2 cmd");
    chk(n_seen[1] === 1 && seen[1].act === d && seen[1].held_only === 1'b1, "l1d");
    chk(n_seen[0] === ((p == ACT_NONE) ? 0 : 1), "l1p cmd count");
    chk(p == ACT_NONE || seen[0].act === p, "l1p cmd kind");
  endtask

  task automatic t_config(input logic [31:0] d, input int np, input int nd);
    clear();
    reg_op(1'b1, 5'h00, d, q, w);
    reg_op(1'b0, 5'h00, 32'h0000_0000, q, w);
    chk(w > 0 && n_seen[0] === np && n_seen[1] === nd, "read not held to end");
    chk(n_seen[2] === 0, "second level touched");
    chk((np == 0 || seen[0].act === ACT_INV) && (nd == 0 || seen[1].act === ACT_INV), "kind");
  endtask

  task automatic t_no_l2();
    @(posedge clock);
    l2_cache_en <= 1'b0;
    clear();
    reg_op(1'b1, 5'h02, 32'h0000_0001, q, w);
    reg_op(1'b1, 5'h14, 32'h0000_1000, q, w);
    reg_op(1'b1, 5'h15, 32'h0000_0010, q, w);
    wait_idle();
    chk(n_seen[0] === 0 && n_seen[1] === 0 && n_seen[2] === 0, "work with l2 off");
    @(posedge clock);
    l2_cache_en <= 1'b1;
  endtask

  // 32 words from 1000h cover two 64-byte lines
  task automatic t_block(input logic [2:0] kd, input cms_act_t p, input cms_act_t d,
                         input cms_act_t l);
    cms_act_t e [3];
    e = '{p, d, l};
    clear();
    reg_op(1'b1, {1'b1, kd, 1'b0}, 32'h0000_1000, q, w);
    reg_op(1'b1, {1'b1, kd, 1'b1}, 32'hFFFF_0020, q, w);
    reg_op(1'b0, {1'b1, kd, 1'b1}, 32'h0000_0000, q, w);
    chk(q !== 32'h0000_0000 && q[31:16] === 16'h0000, "count while busy");
    wait_idle();
    reg_op(1'b0, {1'b1, kd, 1'b1}, 32'h0000_0000, q, w);
    chk(q === 32'h0000_0000, "count after end");
    for (int i = 0; i < 3; i++) begin
      chk(n_seen[i] === ((e[i] == ACT_NONE) ? 0 : 2), "line count");
      chk(e[i] == ACT_NONE || seen[i].act === e[i], "block kind");
      chk(e[i] == ACT_NONE || seen[i].addr === 32'h0000_1040, "last line");
    end
  endtask

  task automatic t_held();
    clear();
    reg_op(1'b1, 5'h12, 32'h0000_1000, q, w);
    reg_op(1'b1, 5'h13, 32'h0000_0010, q, w);
    reg_op(1'b1, 5'h1A, 32'h0000_2000, q, w);
    chk(w > 0 && n_seen[2] === 1, "base write not stalled");
    reg_op(1'b1, 5'h1B, 32'h0000_0010, q, w);
    wait_idle();
    chk(n_seen[1] === 2 && seen[1].act === ACT_INV, "second op");
    chk(seen[1].addr === 32'h0000_2000 && n_seen[2] === 1, "held base lost");
  endtask

  task automatic t_mode();
    @(posedge clock);
    mode_busy <= 1'b1;
    fork
      reg_op(1'b1, 5'h01, 32'h0000_0001, q, w);
      begin
        repeat (6) @(posedge clock);
        mode_busy <= 1'b0;
      end
    join
    chk(w >= 4, "write ran during mode change");
    wait_idle();
  endtask

  task automatic t_misc();
    clear();
    reg_op(1'b1, 5'h01, 32'hFFFF_FFFE, q, w);
    reg_op(1'b1, 5'h11, 32'hFFFF_0000, q, w);
    @(negedge clock);
    chk(op_busy === 1'b0 && n_seen[2] === 0, "op without command");
    reg_op(1'b0, 5'h0F, 32'h0000_0000, q, w);
    chk(q === 32'h0000_0000, "unused select read");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    clear();
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    l2_cache_en = 1'b1;
    mode_busy = 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_global(5'h01, ACT_NONE, ACT_WBINV, ACT_WB);
    t_global(5'h02, ACT_INV, ACT_WBINV, ACT_WBINV);
    t_config(32'h0000_0100, 0, 1);
    t_config(32'h0000_0200, 1, 0);
    t_config(32'h0000_0300, 1, 1);
    t_no_l2();
    t_block(3'h0, ACT_NONE, ACT_WBINV, ACT_WB);
    t_block(3'h1, ACT_INV, ACT_WBINV, ACT_WBINV);
    t_block(3'h2, ACT_INV, ACT_INV, ACT_INV);
    t_block(3'h3, ACT_INV, ACT_NONE, ACT_NONE);
    t_block(3'h4, ACT_NONE, ACT_WBINV, ACT_NONE);
    t_block(3'h5, ACT_NONE, ACT_INV, ACT_NONE);
    t_held();
    t_mode();
    t_misc();
    final_report();
  end
endmodule
